// >>> dv/hoc_erase_model.sv
// memory-side erase responder facing the option loader
// assumes erase_req is a level on core_clk; slow picks the long answer
`timescale 1ns/1ps
`default_nettype none

module hoc_erase_model (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic slow,
    input  wire logic erase_req,
    output logic      erase_done
);
    // ------------------------------------------------------------
    // erase timing
    // ------------------------------------------------------------
    logic [3:0] cnt_q;

    // one-cycle done pulse, 1 or 12 cycles after the request shows;
    // a pulse rather than a level so a stale done never hits idle
    always_ff @(posedge core_clk) begin
        if (reset || !erase_req) begin
            cnt_q      <= 4'h0;
            erase_done <= 1'h0;
        end else begin
            cnt_q      <= cnt_q + 4'h1;
            erase_done <= (cnt_q == (slow ? 4'hB : 4'h0));
        end
    end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the option loader over apb
// assumes hoc_pkg and the erase model are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "hoc_cfg.svh"
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) begin \
            fails++; \
            $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
        end \
    end

module testbench;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic        core_clk = 1'h0;
    logic        reset = 1'h1, por = 1'h1, prog_mode_pin = 1'h1;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        slow = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, erase_done, erase_req, err;
    logic [6:0]  cfg;
    logic [31:0] prdata_f, rd_f;
    logic        pslverr_f, err_f;
    logic [6:0]  cfg_f;
    int          fails = 0, samples_checked = 0;

    hoc_option_loader dut (.core_clk(core_clk), .reset(reset), .por(por),
        .prog_mode_pin(prog_mode_pin), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .erase_done(erase_done),
        .erase_req(erase_req), .watchdog_type_select(cfg[6]),
        .low_voltage_detector_select(cfg[5]),
        .usb_clock_divider_select(cfg[4]), .readout_guard(cfg[3]),
        .watchdog_force_run(cfg[2]), .lvd_enable(cfg[1]),
        .memory_access_block(cfg[0]));

    hoc_erase_model mem (.core_clk(core_clk), .reset(reset), .slow(slow),
        .erase_req(erase_req), .erase_done(erase_done));

    // factory-coded twin on the same bus; its fixed word is arbitrary
    hoc_option_loader #(.FACTORY_CODED(1'h1), .FACTORY_OPTION(8'hD5))
        dut_fc (.core_clk(core_clk), .reset(reset), .por(por),
        .prog_mode_pin(prog_mode_pin), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(),
        .prdata(prdata_f), .pslverr(pslverr_f),
        .erase_done(erase_done), .erase_req(),
        .watchdog_type_select(cfg_f[6]),
        .low_voltage_detector_select(cfg_f[5]),
        .usb_clock_divider_select(cfg_f[4]), .readout_guard(cfg_f[3]),
        .watchdog_force_run(cfg_f[2]), .lvd_enable(cfg_f[1]),
        .memory_access_block(cfg_f[0]));

    always #2 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one apb transfer; an idle edge after it keeps psel writes apart
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) begin
            fails++;
            end_of_test;
        end
        rd = prdata;
        err = pslverr;
        rd_f = prdata_f;
        err_f = pslverr_f;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask

    // transfer plus checks of response and read data
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic [31:0] er,
                        input logic ee);
        apb(w, a, d);
        `CHK("pslverr", ee, err)
        `CHK("prdata", er, rd)
    endtask

    task automatic do_reset(input int n);
        reset <= 1'h1;
        repeat (n) @(posedge core_clk);
        reset <= 1'h0;
        por <= 1'h0;
        // two more edges: guard output and mode synchroniser settle
        repeat (2) @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        do_reset(16);
        `CHK("cfg", 7'h78, cfg)
        `CHK("cfg_f", 7'h0E, cfg_f)
        xfer(0, `HOC_OPTION_OFS, 0, 32'hFF, 0);
        `CHK("rd_f", 32'hD5, rd_f)
        xfer(0, `HOC_STATUS_OFS, 0, 32'hFF00, 0);
        `CHK("st_f", 32'hD502, rd_f)
        // outside programming mode nothing reaches the word
        prog_mode_pin <= 1'h0;
        repeat (3) @(posedge core_clk);
        xfer(1, `HOC_OPTION_OFS, 0, 0, 1);
        xfer(0, `HOC_OPTION_OFS, 0, 0, 1);
        prog_mode_pin <= 1'h1;
        repeat (3) @(posedge core_clk);
        xfer(0, `HOC_OPTION_OFS, 0, 32'hFF, 0);
        xfer(0, 8'h08, 0, 0, 1);
        xfer(1, `HOC_STATUS_OFS, 0, 0, 1);
        xfer(1, `HOC_OPTION_OFS, 32'hFFFFFF00, 0, 0);
        `CHK("wr_f", 1'h1, err_f)
        xfer(0, `HOC_OPTION_OFS, 0, 32'hD4, 0);
        `CHK("rd_f", 32'hD5, rd_f)
        `CHK("cfg", 7'h79, cfg)
        do_reset(4);
        `CHK("wdg", 2'h1, {cfg[6], cfg[2]})
        `CHK("lvd", 2'h1, {cfg[5], cfg[1]})
        `CHK("usb", 1'h0, cfg[4])
        `CHK("guard", 2'h1, {cfg[3], cfg[0]})
        xfer(0, `HOC_STATUS_OFS, 0, 32'hD400, 0);
        // lift the guard with a prompt and then a slow erase
        for (int i = 0; i < 2; i++) begin
            slow <= i[0];
            xfer(1, `HOC_OPTION_OFS, 32'hFF, 0, 0);
            `CHK("erase_req", 2'h3, {erase_req, cfg[0]})
            if (i == 1) begin
                xfer(0, `HOC_OPTION_OFS, 0, 32'hD4, 0);
                xfer(1, `HOC_OPTION_OFS, 0, 0, 1);
                xfer(0, `HOC_STATUS_OFS, 0, 32'hD401, 0);
            end
            n = 0;
            while (erase_req !== 1'h0 && n < 40) begin
                @(posedge core_clk);
                n++;
            end
            if (n >= 40) begin
                fails++;
                end_of_test;
            end
            `CHK("erase_req", 1'h0, erase_req)
            xfer(0, `HOC_OPTION_OFS, 0, 32'hFF, 0);
            `CHK("mab", 1'h0, cfg[0])
            xfer(1, `HOC_OPTION_OFS, 0, 0, 0);
        end
        // guard output follows the store one edge after the last write
        @(posedge core_clk);
        `CHK("cfg", 7'h07, cfg)
        `CHK("cfg_f", 7'h0E, cfg_f)
        end_of_test;
    end
endmodule
`default_nettype wire

// >>> include/hoc_cfg.svh
// constants for the hardware option configuration block
// assumes inclusion by bare name from the package and the design files
`ifndef HOC_CFG_SVH
`define HOC_CFG_SVH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define HOC_OPTION_OFS   8'h00
`define HOC_STATUS_OFS   8'h04

// ---------------------------------------------------------------------
// option word layout and values
// ---------------------------------------------------------------------
`define HOC_OPT_DEFAULT  8'hFF
`define HOC_RSVD_MASK    8'hD4
`define HOC_WDG_BIT      5
`define HOC_LVD_BIT      3
`define HOC_OSC_BIT      1
`define HOC_ROP_BIT      0

// ---------------------------------------------------------------------
// status register layout
// ---------------------------------------------------------------------
`define HOC_ST_BUSY_BIT  0
`define HOC_ST_FACT_BIT  1
`define HOC_ST_CFG_LSB   8

`endif

// >>> include/hoc_pkg.sv
// types shared by the hardware option configuration design
// assumes hoc_cfg.svh is on the include path
package hoc_pkg;
    `include "hoc_cfg.svh"

    // ------------------------------------------------------------------
    // loader state, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        HOC_IDLE  = 2'b01,
        HOC_ERASE = 2'b10
    } hoc_state_t;

    typedef logic [7:0] hoc_word_t;
endpackage

// >>> src/hoc_option_loader.sv
// hardware option word store, loader and apb programming port
// assumes an external programming tool drives apb while prog_mode_pin
// is high; por initialises the store as an unprogrammed part would be;
// erase_done comes from the memory logic on core_clk.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "hoc_cfg.svh"

module hoc_option_loader
    import hoc_pkg::*;
#(
    parameter logic       FACTORY_CODED  = 1'b0,
    parameter logic [7:0] FACTORY_OPTION = 8'hFF  // arbitrary value
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        por,
    input  wire logic        prog_mode_pin,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        erase_done,
    output logic             erase_req,
    output logic             watchdog_type_select,
    output logic             low_voltage_detector_select,
    output logic             usb_clock_divider_select,
    output logic             readout_guard,
    output logic             watchdog_force_run,
    output logic             lvd_enable,
    output logic             memory_access_block
);
    logic       prog_mode;
    hoc_word_t  nv_q;
    hoc_word_t  pending_q;
    hoc_word_t  config_q;
    hoc_word_t  opt_word;
    hoc_state_t state_q;
    logic       pready_q;
    logic       pslverr_q;
    logic [31:0] prdata_q;
    logic       erase_req_q;
    logic       access;
    logic       done;
    logic       bad_d;
    logic [31:0] rdata_d;
    logic       opt_wr;

    hoc_sync u_prog_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (prog_mode_pin),
        .sync_out (prog_mode)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // reserved positions forced high on every store
    function automatic hoc_word_t keep_rsvd(input hoc_word_t w);
        keep_rsvd = w | `HOC_RSVD_MASK;
    endfunction

    // factory parts ignore the programmable store entirely
    assign opt_word = FACTORY_CODED ? FACTORY_OPTION : nv_q;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // one wait state: answer flops load in the first access cycle
    assign access = psel & penable & ~pready_q;
    assign done   = psel & penable & pready_q;

    always_comb begin
        bad_d   = 1'b0;
        rdata_d = 32'h0000_0000;
        if (!prog_mode) begin
            bad_d = 1'b1;
        end else if (paddr == `HOC_OPTION_OFS) begin
            rdata_d = {24'h00_0000, opt_word};
            if (pwrite && (FACTORY_CODED || state_q != HOC_IDLE)) begin
                bad_d = 1'b1;
            end
        end else if (paddr == `HOC_STATUS_OFS) begin
            rdata_d[`HOC_ST_BUSY_BIT] = (state_q == HOC_ERASE);
            rdata_d[`HOC_ST_FACT_BIT] = FACTORY_CODED;
            rdata_d[`HOC_ST_CFG_LSB +: 8] = config_q;
            bad_d = pwrite;
        end else begin
            bad_d = 1'b1;
        end
    end

    // answer flops, read data zero on any error
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= access;
            pslverr_q <= access & bad_d;
            prdata_q  <= (access && !bad_d && !pwrite) ? rdata_d
                                                      : 32'h0000_0000;
        end
    end

    assign opt_wr = done & pwrite & ~pslverr_q &
                    (paddr == `HOC_OPTION_OFS);

    // ------------------------------------------------------------------
    // store and erase sequencing
    // ------------------------------------------------------------------
    // lifting the guard parks the new word until memory is erased
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q     <= HOC_IDLE;
            erase_req_q <= 1'b0;
            pending_q   <= `HOC_OPT_DEFAULT;
        end else begin
            case (state_q)
                HOC_IDLE: begin
                    if (opt_wr && !nv_q[`HOC_ROP_BIT] &&
                        pwdata[`HOC_ROP_BIT]) begin
                        pending_q   <= keep_rsvd(pwdata[7:0]);
                        erase_req_q <= 1'b1;
                        state_q     <= HOC_ERASE;
                    end
                end
                HOC_ERASE: begin
                    if (erase_done) begin
                        erase_req_q <= 1'b0;
                        state_q     <= HOC_IDLE;
                    end
                end
                default: begin
                    erase_req_q <= 1'b0;
                    state_q     <= HOC_IDLE;
                end
            endcase
        end
    end

    // store survives reset; only por blanks it like a fresh part
    always_ff @(posedge core_clk) begin
        if (por) begin
            nv_q <= `HOC_OPT_DEFAULT;
        end else if (!reset && state_q == HOC_ERASE && erase_done) begin
            nv_q <= pending_q;
        end else if (!reset && state_q == HOC_IDLE && opt_wr &&
                     !(!nv_q[`HOC_ROP_BIT] && pwdata[`HOC_ROP_BIT])) begin
            nv_q <= keep_rsvd(pwdata[7:0]);
        end
    end

    // ------------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------------
    // sampled only while reset is high so the chip never sees a
    // selection change mid-run, even after the tool reprograms it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            config_q <= opt_word;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            watchdog_type_select        <= opt_word[`HOC_WDG_BIT];
            watchdog_force_run          <= ~opt_word[`HOC_WDG_BIT];
            low_voltage_detector_select <= opt_word[`HOC_LVD_BIT];
            lvd_enable                  <= ~opt_word[`HOC_LVD_BIT];
            usb_clock_divider_select    <= opt_word[`HOC_OSC_BIT];
            readout_guard               <= opt_word[`HOC_ROP_BIT];
        end
    end

    // guard follows the store on the next edge outside reset, where it is held set, so a lift never exposes memory
    // before the erase has finished
    always_ff @(posedge core_clk) begin
        if (reset) begin
            memory_access_block <= 1'b1;
        end else begin
            memory_access_block <= ~opt_word[`HOC_ROP_BIT] |
                                   (state_q == HOC_ERASE);
        end
    end

    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign prdata    = prdata_q;
    assign erase_req = erase_req_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // no $past here: the store is unknown before the first por edge
    chk_blank_default: assert property (@(posedge core_clk)
        por |=> nv_q == `HOC_OPT_DEFAULT)
        else $error("store not blank after power on");

    chk_prog_only: assert property (@(posedge core_clk)
        disable iff (reset) (access && !prog_mode) |=> pslverr_q && pready_q)
        else $error("access outside programming mode not refused");

    chk_factory_fixed: assert property (@(posedge core_clk)
        FACTORY_CODED |-> opt_word == FACTORY_OPTION)
        else $error("factory word not hard wired");

    chk_watchdog_map: assert property (@(posedge core_clk)
        disable iff (por)
        $past(reset) |-> watchdog_force_run ==
                         !$past(opt_word[`HOC_WDG_BIT]))
        else $error("watchdog selection wrong");

    chk_lvd_map: assert property (@(posedge core_clk)
        disable iff (por)
        $past(reset) |-> lvd_enable == !$past(opt_word[`HOC_LVD_BIT]))
        else $error("detector selection wrong");

    chk_usb_div_map: assert property (@(posedge core_clk)
        disable iff (por)
        $past(reset) |-> usb_clock_divider_select ==
                         $past(opt_word[`HOC_OSC_BIT]))
        else $error("usb divider selection wrong");

    chk_reserved_ones: assert property (@(posedge core_clk)
        disable iff (reset || por)
        (nv_q & `HOC_RSVD_MASK) == `HOC_RSVD_MASK)
        else $error("reserved option bit cleared");

    chk_erase_first: assert property (@(posedge core_clk)
        disable iff (reset || por)
        $rose(nv_q[`HOC_ROP_BIT]) && !$past(por) |->
            $past(erase_done) && $past(erase_req_q))
        else $error("guard lifted without erase");

    chk_guard_block: assert property (@(posedge core_clk)
        disable iff (reset)
        (state_q == HOC_ERASE) |=> memory_access_block)
        else $error("memory open during erase");

    chk_config_static: assert property (@(posedge core_clk)
        !reset && !$past(reset) |-> $stable(config_q) &&
                                    $stable(watchdog_force_run))
        else $error("configuration changed outside reset");
endmodule

`default_nettype wire

// >>> src/hoc_sync.sv
// two-flop synchroniser for a level arriving from a pin
// assumes the level changes slowly relative to core_clk
`timescale 1ns/1ps
`default_nettype none

module hoc_sync (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    // ------------------------------------------------------------------
    // synchroniser chain
    // ------------------------------------------------------------------
    // first flop feeds only the second one
    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

`default_nettype wire
